// ==== crb_pkg.sv ====
// Constants and types shared by the CSI-2 debug and back-link I2C register bank
package crb_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_HS_RX = 8'h22;
  localparam logic [7:0] OFF_LP_RX = 8'h23;
  localparam logic [7:0] OFF_TERM = 8'h24;
  localparam logic [7:0] OFF_RSV_25 = 8'h25;
  localparam logic [7:0] OFF_RSV_26 = 8'h26;
  localparam logic [7:0] OFF_RSV_27 = 8'h27;
  localparam logic [7:0] OFF_RSV_28 = 8'h28;
  localparam logic [7:0] OFF_RSV_29 = 8'h29;
  localparam logic [7:0] OFF_RSV_2A = 8'h2A;
  localparam logic [7:0] OFF_RSV_2B = 8'h2B;
  localparam logic [7:0] OFF_RSV_2D = 8'h2D;
  localparam logic [7:0] OFF_RSV_2E = 8'h2E;
  localparam logic [7:0] OFF_RSV_30 = 8'h30;
  localparam logic [7:0] OFF_HDR = 8'h31;
  localparam logic [7:0] OFF_BLC = 8'h32;

  // Reset values
  localparam logic [7:0] RST_HS_RX = 8'h00;
  localparam logic [7:0] RST_LP_RX = 8'h00;
  localparam logic [7:0] RST_TERM = 8'h00;
  localparam logic [7:0] RST_RSV_25 = 8'h02;
  localparam logic [7:0] RST_RSV_26 = 8'h00;
  localparam logic [7:0] RST_RSV_27 = 8'h00;
  localparam logic [7:0] RST_RSV_28 = 8'h07;
  localparam logic [7:0] RST_RSV_29 = 8'h33;
  localparam logic [7:0] RST_RSV_2A = 8'h01;
  localparam logic [7:0] RST_RSV_2E = 8'h00;
  localparam logic [7:0] RST_HDR = 8'h20;
  localparam logic [7:0] RST_BLC = 8'h09;

  // Writable bit masks; other bits are read-only and hold their reset value
  localparam logic [7:0] WM_HS_RX = 8'h7F;
  localparam logic [7:0] WM_LP_RX = 8'h7F;
  localparam logic [7:0] WM_TERM = 8'hFF;
  localparam logic [7:0] WM_SPLIT = 8'h77;
  localparam logic [7:0] WM_RSV_27 = 8'h07;
  localparam logic [7:0] WM_FULL = 8'hFF;

  // Field positions in the header capture / startup wait register
  localparam int unsigned HDR_PICK_LSB = 6;
  localparam int unsigned HDR_VIEW_BIT = 5;
  localparam int unsigned HDR_PERCH_BIT = 4;
  localparam int unsigned WAIT_LSB = 0;

  // Field positions in the back-link I2C register
  localparam int unsigned BLC_ALL_BIT = 7;
  localparam int unsigned BLC_MATCH_BIT = 6;
  localparam int unsigned BLC_ACK_BIT = 5;
  localparam int unsigned BLC_PAR_BIT = 3;

  // Startup wait timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned WAIT_STEP_US = 100;
  localparam int unsigned WAIT_STEP_CYC = CLK_HZ / 1_000_000 * WAIT_STEP_US;
  localparam int unsigned STEP_CNT_W = 12;

  localparam int unsigned NUM_LANES = 4;
  localparam int unsigned NUM_VC = 4;

  // Packet header as seen on a lane: data id and word count
  typedef struct packed
  {
    logic [1:0] vc;
    logic [5:0] dtype;
    logic [15:0] wcount;
  } crb_hdr_t;

  // One I2C transaction request towards the back link
  typedef struct packed
  {
    logic [6:0] addr;
    logic write;
  } crb_i2c_req_t;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_WAIT,
    ST_RUN
  } crb_start_t;

endpackage

// ==== crb_regs.sv ====
// CSI-2 receive debug and back-link I2C configuration register bank
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module crb_regs
  import crb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Lane side
  input wire logic [NUM_LANES-1:0] lane_lp_ctrl,
  input wire logic hdr_valid,
  input wire crb_hdr_t hdr_raw,
  input wire crb_hdr_t hdr_fixed,
  output logic [NUM_LANES-1:0] lane_lp_ctrl_gated,
  output logic startup_done,
  output crb_hdr_t hdr_report,
  output logic hdr_report_valid,
  output logic [6:0] hs_rx_en,
  output logic [6:0] lp_rx_en,
  output logic [7:0] lane_term_en,
  // I2C forwarding
  input wire logic i2c_req_valid,
  input wire crb_i2c_req_t i2c_req,
  input wire logic [6:0] alias_addr0,
  input wire logic [6:0] remote_target_addr0,
  output logic i2c_fwd_valid,
  output crb_i2c_req_t i2c_fwd,
  output logic i2c_auto_ack,
  output logic parity_check_en
);

  logic [7:0] r_hs;
  logic [7:0] r_lp;
  logic [7:0] r_term;
  logic [7:0] r_rsv [0:5];
  logic [7:0] r_rsv_2e [0:2];
  logic [7:0] r_hdr;
  logic [7:0] r_blc;
  logic [7:0] next_rdata;
  crb_start_t st;
  logic [STEP_CNT_W-1:0] step_cnt;
  logic [2:0] steps_done;
  logic alias_hit;
  logic fwd_ok;

  // High-speed receive enable; bit 7 is read-only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_hs <= RST_HS_RX;
    end
    else if (reg_wr && reg_addr == OFF_HS_RX)
    begin
      r_hs <= reg_wdata & WM_HS_RX;
    end
  end

  // Low-power receive enable; bit 7 is read-only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_lp <= RST_LP_RX;
    end
    else if (reg_wr && reg_addr == OFF_LP_RX)
    begin
      r_lp <= reg_wdata & WM_LP_RX;
    end
  end

  // Termination enable; every bit writable
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_term <= RST_TERM;
    end
    else if (reg_wr && reg_addr == OFF_TERM)
    begin
      r_term <= reg_wdata & WM_TERM;
    end
  end

  // Reserved 0x25-0x2A; masked-off bits are read-only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_rsv[0] <= RST_RSV_25;
      r_rsv[1] <= RST_RSV_26;
      r_rsv[2] <= RST_RSV_27;
      r_rsv[3] <= RST_RSV_28;
      r_rsv[4] <= RST_RSV_29;
      r_rsv[5] <= RST_RSV_2A;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFF_RSV_25: r_rsv[0] <= reg_wdata & WM_SPLIT;
        OFF_RSV_26: r_rsv[1] <= reg_wdata & WM_SPLIT;
        OFF_RSV_27: r_rsv[2] <= reg_wdata & WM_RSV_27;
        OFF_RSV_28: r_rsv[3] <= reg_wdata & WM_SPLIT;
        OFF_RSV_29: r_rsv[4] <= reg_wdata & WM_SPLIT;
        OFF_RSV_2A: r_rsv[5] <= reg_wdata & WM_SPLIT;
        default:
        begin
        end
      endcase
    end
  end

  // Reserved 0x2E-0x30 are plain scratch bytes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_rsv_2e[0] <= RST_RSV_2E;
      r_rsv_2e[1] <= RST_RSV_2E;
      r_rsv_2e[2] <= RST_RSV_2E;
    end
    else if (reg_wr && reg_addr >= OFF_RSV_2E && reg_addr <= OFF_RSV_30)
    begin
      r_rsv_2e[2'(reg_addr - OFF_RSV_2E)] <= reg_wdata;
    end
  end

  // Header capture and startup wait code
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_hdr <= RST_HDR;
    end
    else if (reg_wr && reg_addr == OFF_HDR)
    begin
      r_hdr <= reg_wdata & WM_FULL;
    end
  end

  // Back-link I2C configuration
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_blc <= RST_BLC;
    end
    else if (reg_wr && reg_addr == OFF_BLC)
    begin
      r_blc <= reg_wdata & WM_FULL;
    end
  end

  // Read mux; 0x2B-0x2D have no writable storage and read zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      OFF_HS_RX: next_rdata = r_hs;
      OFF_LP_RX: next_rdata = r_lp;
      OFF_TERM: next_rdata = r_term;
      OFF_RSV_25: next_rdata = r_rsv[0];
      OFF_RSV_26: next_rdata = r_rsv[1];
      OFF_RSV_27: next_rdata = r_rsv[2];
      OFF_RSV_28: next_rdata = r_rsv[3];
      OFF_RSV_29: next_rdata = r_rsv[4];
      OFF_RSV_2A: next_rdata = r_rsv[5];
      OFF_HDR: next_rdata = r_hdr;
      OFF_BLC: next_rdata = r_blc;
      default:
      begin
        if (reg_addr >= OFF_RSV_2E && reg_addr <= OFF_RSV_30)
        begin
          next_rdata = r_rsv_2e[2'(reg_addr - OFF_RSV_2E)];
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // Debug lane enables leave through one register stage; zero is normal operation
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hs_rx_en <= RST_HS_RX[6:0];
      lp_rx_en <= RST_LP_RX[6:0];
      lane_term_en <= RST_TERM;
    end
    else
    begin
      hs_rx_en <= r_hs[6:0];
      lp_rx_en <= r_lp[6:0];
      lane_term_en <= r_term;
    end
  end

  // Startup wait: counts whole 100 us steps after reset release.
  // Code is sampled each step, so a rewrite during the wait takes effect at the end of the current step.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= ST_IDLE;
      step_cnt <= '0;
      steps_done <= 3'h0;
    end
    else
    begin
      case (st)
        ST_IDLE:
        begin
          st <= ST_WAIT;
          step_cnt <= '0;
          steps_done <= 3'h0;
        end
        ST_WAIT:
        begin
          if (step_cnt == STEP_CNT_W'(WAIT_STEP_CYC - 1))
          begin
            step_cnt <= '0;
            if (steps_done >= r_hdr[WAIT_LSB +: 3])
            begin
              st <= ST_RUN;
            end
            else
            begin
              steps_done <= steps_done + 3'h1;
            end
          end
          else
          begin
            step_cnt <= step_cnt + STEP_CNT_W'(1);
          end
        end
        ST_RUN: st <= ST_RUN;
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Low-power control is masked until the wait ends
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lane_lp_ctrl_gated <= '0;
      startup_done <= 1'b0;
    end
    else
    begin
      startup_done <= (st == ST_RUN);
      lane_lp_ctrl_gated <= (st == ST_RUN) ? lane_lp_ctrl : '0;
    end
  end

  // Header report: view picks source, per-channel mode filters by channel
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdr_report <= '0;
      hdr_report_valid <= 1'b0;
    end
    else
    begin
      hdr_report_valid <= 1'b0;
      if (hdr_valid &&
          (!r_hdr[HDR_PERCH_BIT] ||
           hdr_raw.vc == r_hdr[HDR_PICK_LSB +: 2]))
      begin
        hdr_report <= r_hdr[HDR_VIEW_BIT] ? hdr_fixed : hdr_raw;
        hdr_report_valid <= 1'b1;
      end
    end
  end

  assign alias_hit = (i2c_req.addr == alias_addr0);
  assign fwd_ok = r_blc[BLC_ALL_BIT] || (r_blc[BLC_MATCH_BIT] && alias_hit);

  // I2C forwarding decision and alias remap
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i2c_fwd_valid <= 1'b0;
      i2c_fwd <= '0;
      i2c_auto_ack <= 1'b0;
    end
    else
    begin
      i2c_fwd_valid <= i2c_req_valid && fwd_ok;
      i2c_fwd.write <= i2c_req.write;
      i2c_fwd.addr <= alias_hit ? remote_target_addr0 : i2c_req.addr;
      // Ack does not wait for lock or the remote answer
      i2c_auto_ack <= i2c_req_valid && i2c_req.write && r_blc[BLC_ACK_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      parity_check_en <= RST_BLC[BLC_PAR_BIT];
    end
    else
    begin
      parity_check_en <= r_blc[BLC_PAR_BIT];
    end
  end

endmodule
`default_nettype wire

// ==== crb_regs_monitor.sv ====
// Port assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module crb_regs_monitor
  import crb_pkg::*;
(
  // Clock, reset, register port
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Lane and header side
  input wire logic [3:0] lane_lp_ctrl,
  input wire logic [3:0] lane_lp_ctrl_gated,
  input wire logic startup_done,
  input wire logic hdr_valid,
  input wire logic hdr_report_valid,
  // I2C side
  input wire logic i2c_req_valid,
  input wire crb_i2c_req_t i2c_req,
  input wire logic [6:0] alias_addr0,
  input wire logic [6:0] remote_target_addr0,
  input wire logic i2c_fwd_valid,
  input wire crb_i2c_req_t i2c_fwd,
  input wire logic i2c_auto_ack
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_follow;
    $past(startup_done) |-> lane_lp_ctrl_gated == $past(lane_lp_ctrl);
  endproperty
  // Alias hit must leave with the physical address, whatever enabled forwarding
  property p_swap;
    i2c_fwd_valid && $past(i2c_req.addr) == $past(alias_addr0)
      |-> i2c_fwd.addr == $past(remote_target_addr0);
  endproperty
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_lp_block: assert property (!startup_done |-> lane_lp_ctrl_gated == 4'h0)
    else $error("lane control passed in startup wait");
  a_lp_follow: assert property (p_follow)
    else $error("gated lane control not one cycle behind");
  a_done_hold: assert property (startup_done |=> startup_done)
    else $error("startup done dropped");
  a_hdr_cause: assert property (hdr_report_valid |-> $past(hdr_valid))
    else $error("header report without header");
  a_fwd_cause: assert property (i2c_fwd_valid |-> $past(i2c_req_valid))
    else $error("forward without request");
  a_ack_cause: assert property (i2c_auto_ack |-> $past(i2c_req_valid) && $past(i2c_req.write))
    else $error("acknowledge without write");
  a_alias_swap: assert property (p_swap)
    else $error("alias not replaced");
  c_hdr: cover property (hdr_report_valid);
  c_fwd: cover property (i2c_fwd_valid);
  c_done: cover property ($rose(startup_done));
endmodule
bind crb_regs crb_regs_monitor mon (.*);
`default_nettype wire

// ==== crb_partner.sv ====
// Imager lanes and local I2C requester
`timescale 1ns/1ps
`default_nettype none
module crb_partner
  import crb_pkg::*;
(
  // From the bench
  input wire logic core_clk,
  input wire logic hdr_go,
  input wire logic [1:0] vc,
  input wire logic i2c_go,
  input wire crb_i2c_req_t req,
  // Toward the block
  output logic hdr_valid,
  output crb_hdr_t hdr_raw,
  output crb_hdr_t hdr_fixed,
  output logic i2c_req_valid,
  output crb_i2c_req_t i2c_req,
  output logic [3:0] lane_lp_ctrl
);
  // Idle fields inverted so a stale value cannot pass
  assign hdr_valid = hdr_go;
  assign hdr_raw = {vc, 6'h2B, 16'h1234} ^ {24{!hdr_go}};
  assign hdr_fixed = {vc, 6'h2C, 16'h1234} ^ {24{!hdr_go}};
  assign i2c_req_valid = i2c_go;
  assign i2c_req = req ^ {8{!i2c_go}};
  initial lane_lp_ctrl = 4'h3;
  always @(posedge core_clk)
    lane_lp_ctrl <= lane_lp_ctrl + 4'h5;
endmodule
`default_nettype wire

// ==== crb_regs_test.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module crb_regs_test
  import crb_pkg::*;
;
  localparam logic [7:0] RV [17] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h07, 8'h33,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h09};
  localparam logic [7:0] WM [17] = '{8'h7F, 8'h7F, 8'hFF, 8'h77, 8'h77, 8'h07, 8'h77, 8'h77,
    8'h77, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, hdr_go = 1'b0, i2c_go = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lane_term_en;
  logic [1:0] vc = 2'h0;
  logic [6:0] alias_addr0 = 7'h2A, remote_target_addr0 = 7'h55, hs_rx_en, lp_rx_en;
  logic [3:0] lane_lp_ctrl, lane_lp_ctrl_gated;
  logic hdr_valid, hdr_report_valid, startup_done, i2c_req_valid, i2c_fwd_valid;
  logic i2c_auto_ack, parity_check_en;
  crb_hdr_t hdr_raw, hdr_fixed, hdr_report;
  crb_i2c_req_t req = '0, i2c_req, i2c_fwd;
  int n_fail = 0, checks_done = 0;
  crb_partner far (.*);
  crb_regs DUT (.*);
  always #20 core_clk = ~core_clk;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(24'(reg_rdata), 24'(e));
    @(posedge core_clk);
  endtask
  task automatic s_start(input logic [2:0] code);
    int n;
    n = 0;
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    wr(OFF_HDR, {5'h04, code});
    while (startup_done !== 1'b1 && n < 22000)
    begin
      @(negedge core_clk);
      n++;
      if (n == 1000)
        chk(24'(lane_lp_ctrl_gated), 24'h0);
    end
    chk(24'((n + 50) / 100), 24'((int'(code) + 1) * 25));
    chk(24'(lane_lp_ctrl_gated), 24'(4'(lane_lp_ctrl - 4'h5)));
    if (n >= 22000)
    begin
      n_fail++;
      test_done();
    end
    @(posedge core_clk);
  endtask
  task automatic s_regs();
    logic [7:0] a;
    logic [23:0] e3;
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    for (int i = 0; i < 17; i++)
    begin
      a = 8'h22 + 8'(i);
      rd(a, RV[i]);
      wr(a, 8'hFF);
      rd(a, RV[i] | WM[i]);
      e3 = 24'h000000;
      if (i < 3)
        e3[23 - 8 * i -: 8] = WM[i];
      chk({1'b0, hs_rx_en, 1'b0, lp_rx_en, lane_term_en}, e3);
      wr(a, RV[i]);
    end
  endtask
  task automatic s_hdr(input logic [7:0] c, input logic [1:0] v, input logic ev, fx);
    wr(OFF_HDR, c);
    vc <= v;
    hdr_go <= 1'b1;
    @(posedge core_clk);
    hdr_go <= 1'b0;
    @(negedge core_clk);
    chk(24'(hdr_report_valid), 24'(ev));
    if (ev)
      chk(hdr_report, {v, fx ? 6'h2C : 6'h2B, 16'h1234});
    @(posedge core_clk);
  endtask
  task automatic s_i2c(input logic [7:0] c, input logic [7:0] rq, input logic [1:0] ev,
    input logic [6:0] ea);
    wr(OFF_BLC, c);
    req <= rq;
    i2c_go <= 1'b1;
    @(posedge core_clk);
    i2c_go <= 1'b0;
    @(negedge core_clk);
    chk(24'({parity_check_en, i2c_fwd_valid, i2c_auto_ack}), 24'({c[3], ev}));
    if (ev[1])
      chk(24'(i2c_fwd), 24'({ea, rq[0]}));
    @(posedge core_clk);
  endtask
  initial
  begin
    s_start(3'h0);
    s_regs();
    for (int v = 0; v < 4; v++)
    begin
      s_hdr({v[1:0], 6'h30}, v[1:0], 1'b1, 1'b1);
      s_hdr({v[1:0], 6'h10}, v[1:0] + 2'h1, 1'b0, 1'b0);
    end
    s_hdr(8'h40, 2'h3, 1'b1, 1'b0);
    s_i2c(8'h09, 8'h55, 2'h0, 7'h00);
    s_i2c(8'h89, 8'h22, 2'h2, 7'h11);
    s_i2c(8'h49, 8'h23, 2'h0, 7'h00);
    s_i2c(8'h49, 8'h54, 2'h2, 7'h55);
    s_i2c(8'h81, 8'h55, 2'h2, 7'h55);
    s_i2c(8'h21, 8'h23, 2'h1, 7'h00);
    s_i2c(8'h29, 8'h22, 2'h0, 7'h00);
    s_start(3'h7);
    test_done();
  end
endmodule
`default_nettype wire
